// File: include/mph_pkg.sv
package mph_pkg;

    // ==================================================================
    // Register byte offsets
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_STATUS    = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT  = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK  = 8'h0c;
    localparam logic [7:0] REG_DESC_SEL  = 8'h10;
    localparam logic [7:0] REG_DESC_TAG  = 8'h14;
    localparam logic [7:0] REG_LBA_LO    = 8'h18;
    localparam logic [7:0] REG_LBA_HI    = 8'h1c;
    localparam logic [7:0] REG_CNT_LO    = 8'h20;
    localparam logic [7:0] REG_CNT_HI    = 8'h24;
    localparam logic [7:0] REG_CAP_LO    = 8'h28;
    localparam logic [7:0] REG_CAP_HI    = 8'h2c;
    localparam logic [7:0] REG_CHK_LO    = 8'h30;
    localparam logic [7:0] REG_CHK_HI    = 8'h34;
    localparam logic [7:0] REG_CHK_TAG   = 8'h38;
    localparam logic [7:0] REG_NOTCH     = 8'h3c;
    localparam logic [7:0] REG_NOTCH_MAX = 8'h40;
    localparam logic [7:0] REG_START_BND = 8'h44;
    localparam logic [7:0] REG_END_BND   = 8'h48;
    localparam logic [7:0] REG_NOTCHED_L = 8'h4c;
    localparam logic [7:0] REG_NOTCHED_H = 8'h50;
    localparam logic [7:0] REG_ZONE_FLAG = 8'h54;
    localparam logic [7:0] REG_ZONE_RAT  = 8'h58;
    localparam logic [7:0] REG_ZONE_FMT  = 8'h5c;
    localparam logic [7:0] REG_PROTO_LU  = 8'h60;
    localparam logic [7:0] REG_TAG_HDR   = 8'h64;

    // ==================================================================
    // Field positions
    localparam int unsigned CTRL_VALIDATE = 0;
    localparam int unsigned CTRL_LOOKUP   = 1;
    localparam int unsigned DESC_LAST_BIT = 0;
    localparam int unsigned TAG_LSB       = 16;
    localparam int unsigned IRQ_DONE      = 0;
    localparam int unsigned IRQ_ERR       = 1;
    localparam int unsigned IRQ_MISMATCH  = 2;
    localparam int unsigned IRQ_NOTCH     = 3;
    localparam int unsigned IRQ_W         = 4;
    localparam int unsigned ST_BUSY       = 0;
    localparam int unsigned ST_VALID      = 1;
    localparam int unsigned ST_HIT        = 2;
    localparam int unsigned ST_SENSE_LSB  = 8;
    localparam int unsigned ST_ASC_LSB    = 16;

    // ==================================================================
    // Page contents and sense codes
    localparam logic [7:0]  TAG_PAGE_HDR0  = 8'h4a;
    localparam logic [7:0]  TAG_SUBPAGE    = 8'h02;
    localparam logic [7:0]  TAG_DESC_FIRST = 8'h10;
    localparam logic [7:0]  TAG_DESC_BYTES = 8'h18;
    localparam logic [7:0]  ZONE_FLAGS     = 8'h80;
    localparam logic [63:0] PAGES_NOTCHED  = 64'h0000_0000_0000_000c;
    localparam logic [7:0]  PROTO_PAGE     = 8'h18;
    localparam logic [7:0]  PROTO_BYTE2    = 8'h06;
    localparam logic [3:0]  SENSE_ILLEGAL  = 4'h5;
    localparam logic [7:0]  ASC_BAD_PARAM  = 8'h26;

    typedef enum logic [2:0] {
        W_IDLE  = 3'b001,
        W_CHECK = 3'b010,
        W_LOOK  = 3'b100
    } mph_walk_e;

endpackage

// File: rtl/mph_mode_pages.sv
// Functional notes
// R1: Tag subpage is 0Ah/02h; 24-byte descriptors start at byte 16.
// R2: A descriptor with the final flag set ends the valid list.
// R3: Descriptor tag is compared with the tag of data in its range.
// R4: Initiator sets the first descriptor start address to zero.
// R5: Each later start equals previous start plus previous count.
// R6: Last start plus count equals the reported highest block address.
// R7: Invalid combination ends select with illegal request, bad parameter.
// R8: Descriptors with zero block count are ignored.
// R9: Only the active zone selector of the zone page is writable; the code also takes writes to the zone ratio and format fields.
// R10: Zoned drive flag reads one, logical zone flag reads zero.
// R11: Zone zero means all zones; one up to maximum picks one zone.
// R12: Buffer ratios and format fields follow the selected zone.
// R13: Zone boundaries are reported as cylinder and head, writes ignored.
// R14: 64-bit bitmap of zone-dependent pages, bit 63 is page 3Fh.
// R15: Maximum zone count reads as a read-only two-byte value.
// R16: Page 18h protocol identifier 6h, transport retries fixed zero.
// R17: Walk descriptors in order, check each, stop at the final one.
`timescale 1ns/1ps
`default_nettype none

module mph_mode_pages #(
    parameter int unsigned DESC_N       = 8,
    parameter int unsigned ZONES        = 16,
    parameter int unsigned CYL_PER_ZONE = 4096,
    parameter logic [7:0]  HEAD_MAX     = 8'h0f
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output var  logic [31:0] wb_dat_o,
    output var  logic        wb_ack_o,
    output var  logic        irq_o
);
    localparam int unsigned IW = (DESC_N > 1) ? $clog2(DESC_N) : 1;
    localparam int unsigned ZN = ZONES + 1;

    typedef struct packed {
        logic                          ack;
        logic [31:0]                   dat;
        logic                          irq;
        logic [mph_pkg::IRQ_W-1:0]     stat;
        logic [mph_pkg::IRQ_W-1:0]     mask;
        mph_pkg::mph_walk_e            walk;
        logic [IW-1:0]                 idx;
        logic [63:0]                   expect_lba;
        logic [DESC_N-1:0]             last;
        logic [DESC_N-1:0][15:0]       tag;
        logic [DESC_N-1:0][63:0]       lba;
        logic [DESC_N-1:0][63:0]       cnt;
        logic [IW-1:0]                 dsel;
        logic [63:0]                   cap;
        logic [63:0]                   chk_lba;
        logic [15:0]                   chk_tag;
        logic                          valid;
        logic                          hit;
        logic [3:0]                    sense;
        logic [7:0]                    asc;
        logic [15:0]                   notch;
        logic [ZN-1:0][15:0]           ratio;
        logic [ZN-1:0][31:0]           fmt;
    } mph_state_s;

    mph_state_s r_reg;
    mph_state_s r_next;
    // ==================================================================
    // Helpers
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
        logic [31:0] m;
        m = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                m[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return m;
    endfunction

    // Cylinder in the upper three bytes, head in the low byte
    function automatic logic [31:0] bound(input logic [15:0] z,
                                          input logic        at_end);
        logic [31:0] cyl;
        cyl = 32'h0;
        if (z == 16'h0) begin
            cyl = at_end ? 32'(ZONES * CYL_PER_ZONE - 1) : 32'h0;
        end else begin
            cyl = at_end ? 32'(32'(z) * CYL_PER_ZONE - 1)
                         : 32'(32'(z - 16'h1) * CYL_PER_ZONE);
        end
        return {cyl[23:0], at_end ? HEAD_MAX : 8'h00};
    endfunction

    // ==================================================================
    // Next state
    logic        wr;
    logic        ed;
    logic [63:0] cur_lba;
    logic [63:0] cur_cnt;
    logic [63:0] cur_end;
    logic        cur_zero;
    logic        cur_last;
    logic        at_top;
    logic [31:0] rd;
    logic [mph_pkg::IRQ_W-1:0] ev;

    always_comb begin
        r_next   = r_reg;
        ev       = '0;
        rd       = 32'h0;
        wr       = wb_cyc_i && wb_stb_i && wb_we_i && r_reg.ack;
        ed       = r_reg.walk == mph_pkg::W_IDLE;
        cur_lba  = r_reg.lba[r_reg.idx];
        cur_cnt  = r_reg.cnt[r_reg.idx];
        cur_end  = cur_lba + cur_cnt;
        cur_zero = cur_cnt == 64'h0;
        cur_last = r_reg.last[r_reg.idx];
        at_top   = r_reg.idx == IW'(DESC_N - 1);
        r_next.ack = wb_cyc_i && wb_stb_i && !r_reg.ack;
        unique case (wb_adr_i)
            mph_pkg::REG_STATUS:    rd = {8'h0, r_reg.asc, 4'h0, r_reg.sense,
                                          5'h0, r_reg.hit, r_reg.valid, !ed};
            mph_pkg::REG_IRQ_STAT:  rd = 32'(r_reg.stat);
            mph_pkg::REG_IRQ_MASK:  rd = 32'(r_reg.mask);
            mph_pkg::REG_DESC_SEL:  rd = 32'(r_reg.dsel);
            mph_pkg::REG_DESC_TAG:  rd = {r_reg.tag[r_reg.dsel], 15'h0,
                                          r_reg.last[r_reg.dsel]};
            mph_pkg::REG_LBA_LO:    rd = r_reg.lba[r_reg.dsel][31:0];
            mph_pkg::REG_LBA_HI:    rd = r_reg.lba[r_reg.dsel][63:32];
            mph_pkg::REG_CNT_LO:    rd = r_reg.cnt[r_reg.dsel][31:0];
            mph_pkg::REG_CNT_HI:    rd = r_reg.cnt[r_reg.dsel][63:32];
            mph_pkg::REG_CAP_LO:    rd = r_reg.cap[31:0];
            mph_pkg::REG_CAP_HI:    rd = r_reg.cap[63:32];
            mph_pkg::REG_CHK_LO:    rd = r_reg.chk_lba[31:0];
            mph_pkg::REG_CHK_HI:    rd = r_reg.chk_lba[63:32];
            mph_pkg::REG_CHK_TAG:   rd = 32'(r_reg.chk_tag);
            mph_pkg::REG_NOTCH:     rd = 32'(r_reg.notch);
            mph_pkg::REG_NOTCH_MAX: rd = 32'(16'(ZONES));         // [R15]
            mph_pkg::REG_START_BND: rd = bound(r_reg.notch, 1'b0); // [R13]
            mph_pkg::REG_END_BND:   rd = bound(r_reg.notch, 1'b1); // [R13]
            mph_pkg::REG_NOTCHED_L: rd = mph_pkg::PAGES_NOTCHED[31:0]; // [R14]
            mph_pkg::REG_NOTCHED_H: rd = mph_pkg::PAGES_NOTCHED[63:32];
            mph_pkg::REG_ZONE_FLAG: rd = 32'(mph_pkg::ZONE_FLAGS); // [R10]
            mph_pkg::REG_ZONE_RAT:  rd = 32'(r_reg.ratio[r_reg.notch]);
            mph_pkg::REG_ZONE_FMT:  rd = r_reg.fmt[r_reg.notch]; // [R12]
            mph_pkg::REG_PROTO_LU:  rd = {16'h0, mph_pkg::PROTO_BYTE2,
                                          mph_pkg::PROTO_PAGE}; // [R16]
            mph_pkg::REG_TAG_HDR:   rd = {mph_pkg::TAG_DESC_BYTES,
                                          mph_pkg::TAG_DESC_FIRST,
                                          mph_pkg::TAG_SUBPAGE,
                                          mph_pkg::TAG_PAGE_HDR0}; // [R1]
            default:                rd = 32'h0;
        endcase
        if (r_next.ack && !wb_we_i) r_next.dat = rd;

        // Descriptor table is frozen during a walk so a check sees one list
        if (wr) begin
            unique case (wb_adr_i)
                mph_pkg::REG_CTRL: begin
                    if (ed && wb_sel_i[0] && wb_dat_i[mph_pkg::CTRL_VALIDATE]) begin
                        r_next.walk       = mph_pkg::W_CHECK; // [R17]
                        r_next.idx        = '0;
                        r_next.expect_lba = 64'h0;            // [R4]
                        r_next.valid      = 1'b0;
                        r_next.sense      = 4'h0;
                        r_next.asc        = 8'h0;
                    end else if (ed && wb_sel_i[0] &&
                                 wb_dat_i[mph_pkg::CTRL_LOOKUP] && r_reg.valid) begin
                        r_next.walk = mph_pkg::W_LOOK;
                        r_next.idx  = '0;
                        r_next.hit  = 1'b0;
                    end
                end
                mph_pkg::REG_IRQ_STAT:
                    r_next.stat = r_reg.stat & ~wb_dat_i[mph_pkg::IRQ_W-1:0];
                mph_pkg::REG_IRQ_MASK:
                    r_next.mask = wb_dat_i[mph_pkg::IRQ_W-1:0];
                mph_pkg::REG_DESC_SEL:
                    r_next.dsel = wb_dat_i[IW-1:0];
                mph_pkg::REG_DESC_TAG: begin
                    if (ed) begin
                        if (wb_sel_i[0]) begin
                            r_next.last[r_reg.dsel] = wb_dat_i[mph_pkg::DESC_LAST_BIT];
                        end
                        r_next.tag[r_reg.dsel] = 16'(merge(
                            {r_reg.tag[r_reg.dsel], 16'h0}, wb_dat_i,
                            wb_sel_i) >> mph_pkg::TAG_LSB);
                        r_next.valid = 1'b0;
                    end
                end
                mph_pkg::REG_LBA_LO, mph_pkg::REG_LBA_HI: begin
                    if (ed) begin
                        r_next.lba[r_reg.dsel][wb_adr_i[2]*32 +: 32] =
                            merge(r_reg.lba[r_reg.dsel][wb_adr_i[2]*32 +: 32],
                                  wb_dat_i, wb_sel_i);
                        r_next.valid = 1'b0;
                    end
                end
                mph_pkg::REG_CNT_LO, mph_pkg::REG_CNT_HI: begin
                    if (ed) begin
                        r_next.cnt[r_reg.dsel][wb_adr_i[2]*32 +: 32] =
                            merge(r_reg.cnt[r_reg.dsel][wb_adr_i[2]*32 +: 32],
                                  wb_dat_i, wb_sel_i);
                        r_next.valid = 1'b0;
                    end
                end
                mph_pkg::REG_CAP_LO, mph_pkg::REG_CAP_HI:
                    r_next.cap[wb_adr_i[2]*32 +: 32] =
                        merge(r_reg.cap[wb_adr_i[2]*32 +: 32], wb_dat_i, wb_sel_i);
                mph_pkg::REG_CHK_LO, mph_pkg::REG_CHK_HI:
                    r_next.chk_lba[wb_adr_i[2]*32 +: 32] =
                        merge(r_reg.chk_lba[wb_adr_i[2]*32 +: 32], wb_dat_i, wb_sel_i);
                mph_pkg::REG_CHK_TAG:
                    r_next.chk_tag = 16'(merge(32'(r_reg.chk_tag), wb_dat_i,
                                               wb_sel_i));
                mph_pkg::REG_NOTCH: begin
                    // Out-of-range zone is refused, the old selection stays
                    if (wb_dat_i[15:0] <= 16'(ZONES)) begin
                        r_next.notch = wb_dat_i[15:0]; // [R9] [R11]
                    end else begin
                        ev[mph_pkg::IRQ_NOTCH] = 1'b1;
                    end
                end
                mph_pkg::REG_ZONE_RAT:
                    r_next.ratio[r_reg.notch] =
                        16'(merge(32'(r_reg.ratio[r_reg.notch]), wb_dat_i,
                                  wb_sel_i)); // [R12]
                mph_pkg::REG_ZONE_FMT:
                    r_next.fmt[r_reg.notch] =
                        merge(r_reg.fmt[r_reg.notch], wb_dat_i, wb_sel_i); // [R12]
                // Boundaries, flags, bitmap and page 18h ignore writes
                default: ;
            endcase
        end

        // ==============================================================
        // Descriptor walk, one descriptor per cycle
        unique case (r_reg.walk)
            mph_pkg::W_IDLE: ;
            mph_pkg::W_CHECK: begin
                if (!cur_zero) r_next.expect_lba = cur_end; // [R8] [R5]
                if (!cur_zero && cur_lba != r_reg.expect_lba) begin
                    r_next.walk  = mph_pkg::W_IDLE; // [R4] [R5]
                    r_next.sense = mph_pkg::SENSE_ILLEGAL; // [R7]
                    r_next.asc   = mph_pkg::ASC_BAD_PARAM;
                    ev[mph_pkg::IRQ_ERR] = 1'b1;
                end else if (cur_last || at_top) begin
                    r_next.walk = mph_pkg::W_IDLE; // [R2] [R17]
                    if (cur_last && r_next.expect_lba == r_reg.cap) begin
                        r_next.valid = 1'b1; // [R6]
                        ev[mph_pkg::IRQ_DONE] = 1'b1;
                    end else begin
                        r_next.sense = mph_pkg::SENSE_ILLEGAL; // [R7]
                        r_next.asc   = mph_pkg::ASC_BAD_PARAM;
                        ev[mph_pkg::IRQ_ERR] = 1'b1;
                    end
                end else begin
                    r_next.idx = r_reg.idx + IW'(1);
                end
            end
            mph_pkg::W_LOOK: begin
                if (!cur_zero && r_reg.chk_lba >= cur_lba &&
                    r_reg.chk_lba < cur_end) begin
                    r_next.walk = mph_pkg::W_IDLE;
                    r_next.hit  = 1'b1;
                    ev[mph_pkg::IRQ_DONE] = 1'b1;
                    if (r_reg.tag[r_reg.idx] != r_reg.chk_tag) begin
                        ev[mph_pkg::IRQ_MISMATCH] = 1'b1; // [R3]
                    end
                end else if (cur_last || at_top) begin
                    r_next.walk = mph_pkg::W_IDLE; // [R2]
                    ev[mph_pkg::IRQ_DONE] = 1'b1;
                end else begin
                    r_next.idx = r_reg.idx + IW'(1);
                end
            end
            default: r_next.walk = mph_pkg::W_IDLE;
        endcase

        // A new event wins over a clear in the same cycle
        r_next.stat = r_next.stat | ev;
        r_next.irq  = |(r_next.stat & r_next.mask);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r_reg      <= '0;
            r_reg.walk <= mph_pkg::W_IDLE;
        end else begin
            r_reg <= r_next;
        end
    end

    assign wb_dat_o = r_reg.dat;
    assign wb_ack_o = r_reg.ack;
    assign irq_o    = r_reg.irq;

    // ==================================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held for two cycles");
    ack_follow_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    irq_gate_a: assert property (irq_o == |(r_reg.stat & r_reg.mask))
        else $error("interrupt does not match masked status");
    err_sense_a: assert property ($rose(r_reg.stat[mph_pkg::IRQ_ERR]) // [R7]
        |-> r_reg.sense == mph_pkg::SENSE_ILLEGAL &&
        r_reg.asc == mph_pkg::ASC_BAD_PARAM) else $error("no illegal sense");
    valid_cap_a: assert property ($rose(r_reg.valid) |-> // [R6]
        r_reg.expect_lba == r_reg.cap)
        else $error("table valid but end differs from capacity");
    notch_range_a: assert property (r_reg.notch <= 16'(ZONES)) // [R11]
        else $error("active zone beyond maximum");
    zone_flag_a: assert property (wb_ack_o && $past(!wb_we_i) && // [R10]
        $past(wb_adr_i) == mph_pkg::REG_ZONE_FLAG |->
        wb_dat_o == 32'(mph_pkg::ZONE_FLAGS)) else $error("zone flags wrong");
    proto_ro_a: assert property (wb_ack_o && $past(!wb_we_i) && // [R16]
        $past(wb_adr_i) == mph_pkg::REG_PROTO_LU |->
        wb_dat_o[15:8] == mph_pkg::PROTO_BYTE2) else $error("page 18h wrong");
    walk_end_a: assert property (r_reg.walk == mph_pkg::W_CHECK && // [R2]
        cur_last && !cur_zero && cur_lba == r_reg.expect_lba |=>
        r_reg.walk == mph_pkg::W_IDLE) else $error("walk ran past final");

    check_ok_c: cover property ($rose(r_reg.valid));
    check_err_c: cover property ($rose(r_reg.stat[mph_pkg::IRQ_ERR]));
    tag_miss_c: cover property ($rose(r_reg.stat[mph_pkg::IRQ_MISMATCH]));
    notch_bad_c: cover property ($rose(r_reg.stat[mph_pkg::IRQ_NOTCH]));
endmodule
`default_nettype wire

// File: verification/mph_initiator.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Initiator model: classic single-cycle register master
module mph_initiator (
    input  wire logic        clk,
    output var  logic        cyc,
    output var  logic        stb,
    output var  logic        we,
    output var  logic [7:0]  adr,
    output var  logic [3:0]  sel,
    output var  logic [31:0] dat_w,
    input  wire logic [31:0] dat_r,
    input  wire logic        ack,
    output var  logic        hung
);
    initial begin
        {cyc, stb, we, adr, sel, dat_w, hung} = '0;
    end

    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        sel <= 4'hf;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 64);
        if (n >= 64) hung = 1'b1;
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        // Released data shows the inverse so stale values never match
        dat_w <= ~d;
    endtask

    // One tag descriptor: select, flag and tag, start, count
    task automatic load_desc(input logic [7:0] i, input logic [15:0] tag,
                             input logic last, input logic [63:0] lba,
                             input logic [63:0] cnt);
        logic [31:0] q;
        xfer(1'b1, mph_pkg::REG_DESC_SEL, {24'h0, i}, q);
        xfer(1'b1, mph_pkg::REG_DESC_TAG, {tag, 15'h0, last}, q);
        xfer(1'b1, mph_pkg::REG_LBA_LO, lba[31:0], q);
        xfer(1'b1, mph_pkg::REG_LBA_HI, lba[63:32], q);
        xfer(1'b1, mph_pkg::REG_CNT_LO, cnt[31:0], q);
        xfer(1'b1, mph_pkg::REG_CNT_HI, cnt[63:32], q);
    endtask
endmodule
`default_nettype wire

// File: verification/test_mode_page_tag_notch_handler.sv
`timescale 1ns/1ps
`default_nettype none
module test_mode_page_tag_notch_handler;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        cyc, stb, we, ack, irq, hung;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dw, dr, q, rnd = 32'h9b9cf9d0;
    logic [63:0] lba, cap, cnt[8], st[8];
    logic [15:0] tg[8];
    int          error_cnt = 0, cmp_count = 0, cyc_cnt = 0, n, k;

    always #12.5 clk = ~clk;

    mph_mode_pages dut (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .irq_o(irq));
    mph_initiator bus (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
        .sel(sel), .dat_w(dw), .dat_r(dr), .ack(ack), .hung(hung));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Registered outputs settle after the edge that ends a transfer
    task automatic chk_irq(input string nm, input logic e);
        @(negedge clk);
        check(nm, irq, e);
    endtask

    task automatic rd(input logic [7:0] a);
        rnd = xs(rnd);
        bus.xfer(1'b0, a, rnd, q);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus.xfer(1'b1, a, d, q);
    endtask

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Hang guard sized well above the whole sequence
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 60000 || hung === 1'b1) begin
            error_cnt++;
            stop_test;
        end
    end

    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        // ==========================================================
        // Fixed page contents
        rd(mph_pkg::REG_TAG_HDR);   check("tag hdr", q, 32'h1810024a);
        rd(mph_pkg::REG_ZONE_FLAG); check("zflags", q, 32'h80);
        rd(mph_pkg::REG_NOTCH_MAX); check("zmax", q, 32'h10);
        wr(mph_pkg::REG_NOTCH_MAX, 32'h5);
        rd(mph_pkg::REG_NOTCH_MAX); check("zmax ro", q, 32'h10);
        rd(mph_pkg::REG_NOTCHED_L); check("bmp lo", q, 32'hc);
        rd(mph_pkg::REG_NOTCHED_H); check("bmp hi", q, 32'h0);
        wr(mph_pkg::REG_PROTO_LU, 32'hffffffff);
        rd(mph_pkg::REG_PROTO_LU); check("p18", q[15:0], 16'h0618);
        rd(8'hfc);                  check("unmapped", q, 32'h0);
        // ==========================================================
        // Zone selection, boundaries and refused values
        wr(mph_pkg::REG_IRQ_MASK, 32'h0);
        for (int z = 0; z <= 17; z++) begin
            wr(mph_pkg::REG_NOTCH, z);
            wr(mph_pkg::REG_START_BND, rnd);
            rd(mph_pkg::REG_NOTCH); check("zone", q, (z > 16) ? 16 : z);
            if (z <= 16) begin
                rd(mph_pkg::REG_START_BND);
                check("start", q, (z == 0) ? 0 : (z - 1) * 4096 * 256);
                rd(mph_pkg::REG_END_BND);
                check("end", q, {24'((z == 0 ? 16 : z) * 4096 - 1), 8'h0f});
            end
        end
        rd(mph_pkg::REG_IRQ_STAT); check("zone irq", q, 32'h8);
        check("masked", irq, 1'b0);
        wr(mph_pkg::REG_IRQ_MASK, 32'hf);
        chk_irq("irq on", 1'b1);
        wr(mph_pkg::REG_IRQ_STAT, 32'hf);
        chk_irq("irq off", 1'b0);
        wr(mph_pkg::REG_NOTCH, 3); wr(mph_pkg::REG_ZONE_RAT, 32'h1234);
        wr(mph_pkg::REG_ZONE_FMT, 32'hc0de0003);
        wr(mph_pkg::REG_NOTCH, 5); wr(mph_pkg::REG_ZONE_RAT, 32'h5678);
        wr(mph_pkg::REG_ZONE_FMT, 32'hc0de0005);
        wr(mph_pkg::REG_NOTCH, 3);
        rd(mph_pkg::REG_ZONE_RAT); check("ratio", q[15:0], 16'h1234);
        rd(mph_pkg::REG_ZONE_FMT); check("fmt", q, 32'hc0de0003);
        // ==========================================================
        // Descriptor chains: bad start, bad end, then good
        for (int t = 0; t < 3; t++) begin
            rnd = xs(rnd);
            n = 3 + rnd[1:0];
            lba = 0;
            for (int i = 0; i <= n; i++) begin
                rnd = xs(rnd);
                cnt[i] = (i == 1) ? 0 : {48'h0, rnd[15:0]} + 1;
                st[i] = (i == 1) ? {32'h0, xs(rnd)} : lba;
                tg[i] = rnd[31:16];
                if (t == 0 && i == 2) st[i] = st[i] + 1;
                // Entry past the final one is garbage and must be skipped
                if (i == n) st[i] = 64'h77;
                bus.load_desc(i, tg[i], i >= n - 1, st[i], cnt[i]);
                if (i != 1 && i < n) lba = lba + cnt[i];
            end
            cap = lba + ((t == 1) ? 1 : 0);
            wr(mph_pkg::REG_CAP_LO, cap[31:0]);
            wr(mph_pkg::REG_CAP_HI, cap[63:32]);
            wr(mph_pkg::REG_IRQ_STAT, 32'hf);
            wr(mph_pkg::REG_CTRL, 32'h1);
            k = 0;
            do begin
                rd(mph_pkg::REG_STATUS);
                k++;
            end while (q[mph_pkg::ST_BUSY] !== 1'b0 && k < 100);
            check("busy", q[mph_pkg::ST_BUSY], 1'b0);
            check("valid", q[mph_pkg::ST_VALID], t == 2);
            check("sense", {q[23:16], q[11:8]}, (t < 2) ? 12'h265 : 12'h0);
            rd(mph_pkg::REG_IRQ_STAT);
            check("irq st", q[1:0], (t == 2) ? 2'b01 : 2'b10);
            check("irq lvl", irq, 1'b1);
        end
        // ==========================================================
        // Tag lookup inside the third entry, mismatch then match
        for (int m = 0; m < 2; m++) begin
            rnd = xs(rnd);
            lba = st[2] + (rnd % cnt[2]);
            wr(mph_pkg::REG_IRQ_STAT, 32'hf);
            wr(mph_pkg::REG_CHK_LO, lba[31:0]);
            wr(mph_pkg::REG_CHK_HI, lba[63:32]);
            wr(mph_pkg::REG_CHK_TAG, {16'h0, tg[2] ^ (m == 0)});
            wr(mph_pkg::REG_CTRL, 32'h2);
            repeat (20) rd(mph_pkg::REG_TAG_HDR);
            rd(mph_pkg::REG_STATUS); check("hit", q[2], 1'b1);
            rd(mph_pkg::REG_IRQ_STAT);
            check("tag irq", q[2:0], (m == 0) ? 3'b101 : 3'b001);
        end
        stop_test;
    end
endmodule
`default_nettype wire
